/* src/sesf_pkg.sv */
// Purpose: shared constants for the serial memory slave front end
// Assumes: 8-bit opcodes, eight sectors of 64 KiB, 256-byte page buffer
// Notes: status byte layout and extended byte layout live here

package sesf_pkg;

    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_STATE = 8'h01;
    localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
    localparam logic [7:0] OP_ARRAY_READ = 8'h03;
    localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
    localparam logic [7:0] OP_READ_STATE = 8'h05;
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_VOL_EXT_WRITE = 8'hE3;
    localparam logic [7:0] OP_PER_EXT_WRITE = 8'hE4;
    localparam logic [7:0] OP_PREP_WEAR = 8'hE8;
    localparam logic [7:0] OP_PREP_SUPPLY = 8'hE9;
    localparam logic [7:0] OP_FETCH_PREP = 8'hF9;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int SR_LOCK_EN_BIT = 7;
    localparam int SR_FIELD_LSB = 2;
    localparam int SR_WEN_BIT = 1;
    localparam int SR_RDY_BIT = 0;
    localparam int XSR_WRAP_BIT = 0;
    localparam int SECTOR_LSB = 16;
    localparam logic [1:0] LOCK_NONE = 2'h0;
    localparam logic [1:0] LOCK_QUARTER = 2'h1;
    localparam logic [1:0] LOCK_HALF = 2'h2;
    localparam logic [1:0] LOCK_ALL = 2'h3;

    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [1:0] LOCK_FIELD_RST = 2'h0;
    localparam logic LOCK_EN_RST = 1'b0;
    localparam logic WRAP_SEL_RST = 1'b0;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [1:0] LAST_ADDR_BYTE = 2'h2;
    localparam logic [8:0] PAGE_BYTES = 9'h100;

endpackage

/* src/sesf_pbuf_if.sv */
// Purpose: carrier between the front end and its page buffer
// Assumes: one write port, one registered read port
// Notes: none

`timescale 1ns/1ps

interface sesf_pbuf_if;
    logic we;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic [7:0] raddr;
    logic [7:0] rdata;

    modport fe (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* src/sesf_pbuf.sv */
// Purpose: 256-byte page buffer with registered read data
// Assumes: single clock, write and read may share a cycle
// Notes: contents are not reset, only the read register is

`timescale 1ns/1ps

module sesf_pbuf
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    sesf_pbuf_if.mem bus
);

    logic [7:0] mem_r [0:255];

    always_ff @(posedge i_sys_clk)
    begin
        if (bus.we)
        begin
            mem_r[bus.waddr] <= bus.wdata;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            bus.rdata <= 8'h00;
        end
        else
        begin
            bus.rdata <= mem_r[bus.raddr];
        end
    end

endmodule // sesf_pbuf

/* src/sesf_front.sv */
// Purpose: serial slave front end of a sectored nonvolatile memory
// Assumes: serial clock well below a quarter of i_sys_clk; pins are asynchronous
// Notes: array data must answer a fetch within two clocks
//
// Behaviour
// - slave works in clock mode 0 or mode 3 only.
// - input sampled on serial clock rise, output changed on its fall.
// - falling edges before the first rise of a frame are ignored.
// - transfers are whole bytes, most significant bit first.
// - select low opens a transaction; its first byte is the opcode.
// - pause low floats output and ignores clock and input until release.
// - while busy only the read-state command is serviced.
// - unknown opcode ignored, output stays floating for the transaction.
// - volatile writes last until power cycle; persistent writes are reloaded.
// - opcode 02h is array write (long), 03h is array read.
// - 06h sets, 04h clears the latch; also cleared at reset and writes.
// - E3h and E4h write the extended status, volatile and persistent.
// - E8h and E9h prepare a result, fetched later with F9h.
// - read takes sector byte then 16-bit offset; low three sector bits.
// - after the last address byte, array bytes stream until deselect.
// - read pointer increments; wraps in sector or runs across sectors.
// - array read or write while programming is treated as invalid.
// - read accepted only when the addressed sector is powered up.
// - array write needs not busy, latch set and sector unprotected.
// - status lock active when lock enable set and guard input low.
// - write takes 1 to 256 data bytes; programming starts on deselect.
// - lock field 00 none, 01 sectors 6-7, 10 sectors 4-7, 11 all.

`timescale 1ns/1ps

module sesf_front
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_si,
    input wire logic i_hold_n,
    input wire logic i_wp_n,
    input wire logic i_busy,
    input wire logic [7:0] i_sector_awake,
    input wire logic [7:0] i_arr_rd_data,
    input wire logic i_arr_rd_valid,
    input wire logic [7:0] i_prepared_data,
    input wire logic [7:0] i_pbuf_raddr,
    input wire logic i_nv_load,
    input wire logic [7:0] i_nv_sr,
    input wire logic [7:0] i_nv_xsr,
    output logic o_so,
    output logic o_so_oe,
    output logic o_arr_rd_en,
    output logic [18:0] o_arr_addr,
    output logic o_prog_start,
    output logic [18:0] o_prog_addr,
    output logic [8:0] o_prog_len,
    output logic [7:0] o_pbuf_rdata,
    output logic o_persist_wr,
    output logic [7:0] o_persist_sr,
    output logic [7:0] o_persist_xsr,
    output logic o_prepare_wear,
    output logic o_prepare_supply,
    output logic [7:0] o_status
);

    typedef enum logic [6:0]
    {
        ST_OP = 7'b000_0001,
        ST_ADDR = 7'b000_0010,
        ST_WDATA = 7'b000_0100,
        ST_SDATA = 7'b000_1000,
        ST_RSTREAM = 7'b001_0000,
        ST_STREAM = 7'b010_0000,
        ST_DISCARD = 7'b100_0000
    } sesf_state_e;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] pin_s1_r;
    logic [4:0] pin_s2_r;
    logic sck_s3_r;
    logic cs_s3_r;

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pin_s1_r <= 5'h1C;
            pin_s2_r <= 5'h1C;
            sck_s3_r <= 1'b0;
            cs_s3_r <= 1'b1;
        end
        else
        begin
            pin_s1_r <= {i_wp_n, i_hold_n, i_cs_n, i_si, i_sck};
            pin_s2_r <= pin_s1_r;
            sck_s3_r <= pin_s2_r[0];
            cs_s3_r <= pin_s2_r[2];
        end
    end

    logic sck_s;
    logic si_s;
    logic cs_n_s;
    logic hold_n_s;
    logic wp_n_s;
    assign sck_s = pin_s2_r[0];
    assign si_s = pin_s2_r[1];
    assign cs_n_s = pin_s2_r[2];
    assign hold_n_s = pin_s2_r[3];
    assign wp_n_s = pin_s2_r[4];

    // edges only count inside a frame and outside a pause
    logic live;
    logic rise_ev;
    logic fall_ev;
    logic cs_rise;
    assign live = !cs_n_s && hold_n_s;
    assign rise_ev = live && sck_s && !sck_s3_r;
    assign fall_ev = live && !sck_s && sck_s3_r;
    assign cs_rise = cs_n_s && !cs_s3_r;

    // ------------------------------------------------------------
    // receive shifter
    // ------------------------------------------------------------
    logic [2:0] bit_cnt_r;
    logic [6:0] rx_r;
    logic seen_rise_r;
    logic byte_done;
    logic [7:0] rx_byte;
    assign byte_done = rise_ev && (bit_cnt_r == sesf_pkg::LAST_BIT);
    assign rx_byte = {rx_r, si_s};

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            bit_cnt_r <= 3'h0;
            rx_r <= 7'h00;
            seen_rise_r <= 1'b0;
        end
        else if (cs_n_s)
        begin
            bit_cnt_r <= 3'h0;
            seen_rise_r <= 1'b0;
        end
        else if (rise_ev)
        begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            rx_r <= rx_byte[6:0];
            seen_rise_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // status and settings
    // ------------------------------------------------------------
    logic wen_r;
    logic lock_en_r;
    logic [1:0] lock_field_r;
    logic wrap_full_r;
    logic busy;
    logic status_lock;
    assign busy = i_busy;
    assign status_lock = lock_en_r && !wp_n_s;

    function automatic logic sector_locked(input logic [1:0] fld, input logic [2:0] sec);
        case (fld)
            sesf_pkg::LOCK_NONE: sector_locked = 1'b0;
            sesf_pkg::LOCK_QUARTER: sector_locked = (sec[2:1] == 2'h3);
            sesf_pkg::LOCK_HALF: sector_locked = sec[2];
            default: sector_locked = 1'b1;
        endcase
    endfunction

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    sesf_state_e st_r;
    logic [7:0] op_r;
    logic [1:0] addr_cnt_r;
    logic [15:0] addr_r;
    logic [8:0] wcnt_r;
    logic [7:0] sr_hold_r;
    logic stream_prep_r;
    logic [23:0] addr_full;
    logic [2:0] sec;
    logic addr_last;
    logic start_read;
    logic start_write;
    assign addr_full = {addr_r, rx_byte};
    assign sec = addr_full[sesf_pkg::SECTOR_LSB +: 3];
    assign addr_last = byte_done && (st_r == ST_ADDR)
        && (addr_cnt_r == sesf_pkg::LAST_ADDR_BYTE);
    assign start_read = addr_last && (op_r == sesf_pkg::OP_ARRAY_READ)
        && !busy && i_sector_awake[sec];
    assign start_write = addr_last && (op_r == sesf_pkg::OP_ARRAY_WRITE)
        && !busy && wen_r && !sector_locked(lock_field_r, sec);

    logic guarded_ok;
    assign guarded_ok = wen_r && !status_lock;

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_r <= ST_OP;
            op_r <= 8'h00;
            addr_cnt_r <= 2'h0;
            addr_r <= 16'h0000;
            sr_hold_r <= 8'h00;
            stream_prep_r <= 1'b0;
        end
        else if (cs_n_s)
        begin
            st_r <= ST_OP;
            addr_cnt_r <= 2'h0;
        end
        else if (byte_done)
        begin
            case (st_r)
                ST_OP:
                begin
                    op_r <= rx_byte;
                    if (busy && rx_byte != sesf_pkg::OP_READ_STATE)
                    begin
                        st_r <= ST_DISCARD;
                    end
                    else
                    begin
                        case (rx_byte)
                            sesf_pkg::OP_READ_STATE:
                            begin
                                st_r <= ST_STREAM;
                                stream_prep_r <= 1'b0;
                            end
                            sesf_pkg::OP_FETCH_PREP:
                            begin
                                st_r <= ST_STREAM;
                                stream_prep_r <= 1'b1;
                            end
                            sesf_pkg::OP_ARRAY_READ, sesf_pkg::OP_ARRAY_WRITE:
                                st_r <= ST_ADDR;
                            sesf_pkg::OP_WRITE_STATE, sesf_pkg::OP_VOL_EXT_WRITE,
                            sesf_pkg::OP_PER_EXT_WRITE:
                                st_r <= guarded_ok ? ST_SDATA : ST_DISCARD;
                            default:
                                st_r <= ST_DISCARD;
                        endcase
                    end
                end
                ST_ADDR:
                begin
                    addr_r <= addr_full[15:0];
                    addr_cnt_r <= addr_cnt_r + 2'h1;
                    if (addr_cnt_r == sesf_pkg::LAST_ADDR_BYTE)
                    begin
                        st_r <= start_read ? ST_RSTREAM
                            : (start_write ? ST_WDATA : ST_DISCARD);
                    end
                end
                ST_SDATA:
                begin
                    sr_hold_r <= rx_byte;
                    if (op_r == sesf_pkg::OP_WRITE_STATE || addr_cnt_r != 2'h0)
                    begin
                        st_r <= ST_DISCARD;
                    end
                    addr_cnt_r <= 2'h1;
                end
                ST_WDATA, ST_RSTREAM, ST_STREAM, ST_DISCARD:
                    st_r <= st_r;
                default:
                    st_r <= ST_DISCARD;
            endcase
        end
    end

    // setting writes land on their last data byte
    logic sdata_done;
    logic sr_apply;
    logic xsr_apply;
    logic prepare_ok;
    assign sdata_done = byte_done && (st_r == ST_SDATA) && !busy;
    assign sr_apply = sdata_done && (op_r == sesf_pkg::OP_WRITE_STATE);
    assign xsr_apply = sdata_done && (op_r != sesf_pkg::OP_WRITE_STATE)
        && (addr_cnt_r != 2'h0);
    assign prepare_ok = byte_done && (st_r == ST_OP) && !busy;

    logic [7:0] new_sr;
    assign new_sr = sr_apply ? rx_byte : sr_hold_r;

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wen_r <= 1'b0;
            lock_en_r <= sesf_pkg::LOCK_EN_RST;
            lock_field_r <= sesf_pkg::LOCK_FIELD_RST;
            wrap_full_r <= sesf_pkg::WRAP_SEL_RST;
        end
        else
        begin
            if (i_nv_load)
            begin
                lock_en_r <= i_nv_sr[sesf_pkg::SR_LOCK_EN_BIT];
                lock_field_r <= i_nv_sr[sesf_pkg::SR_FIELD_LSB +: 2];
                wrap_full_r <= i_nv_xsr[sesf_pkg::XSR_WRAP_BIT];
            end
            if (sr_apply || xsr_apply)
            begin
                lock_en_r <= new_sr[sesf_pkg::SR_LOCK_EN_BIT];
                lock_field_r <= new_sr[sesf_pkg::SR_FIELD_LSB +: 2];
            end
            if (xsr_apply)
            begin
                wrap_full_r <= rx_byte[sesf_pkg::XSR_WRAP_BIT];
            end
            if (prepare_ok && rx_byte == sesf_pkg::OP_SET_LATCH)
            begin
                wen_r <= 1'b1;
            end
            else if ((prepare_ok && rx_byte == sesf_pkg::OP_CLEAR_LATCH)
                || sr_apply || xsr_apply || (cs_rise && st_r == ST_WDATA))
            begin
                wen_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // events towards the array controller
    // ------------------------------------------------------------
    sesf_pbuf_if pbuf();

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wcnt_r <= 9'h000;
            o_prog_start <= 1'b0;
            o_prog_addr <= 19'h0_0000;
            o_prog_len <= 9'h000;
            o_persist_wr <= 1'b0;
            o_persist_sr <= 8'h00;
            o_persist_xsr <= 8'h00;
            o_prepare_wear <= 1'b0;
            o_prepare_supply <= 1'b0;
            pbuf.we <= 1'b0;
            pbuf.waddr <= 8'h00;
            pbuf.wdata <= 8'h00;
        end
        else
        begin
            pbuf.we <= 1'b0;
            if (start_write)
            begin
                o_prog_addr <= addr_full[18:0];
                wcnt_r <= 9'h000;
            end
            else if (byte_done && st_r == ST_WDATA && wcnt_r != sesf_pkg::PAGE_BYTES)
            begin
                pbuf.we <= 1'b1;
                pbuf.waddr <= o_prog_addr[7:0] + wcnt_r[7:0];
                pbuf.wdata <= rx_byte;
                wcnt_r <= wcnt_r + 9'h001;
            end
            // programming only for a write with at least one whole byte
            o_prog_start <= cs_rise && (st_r == ST_WDATA) && (wcnt_r != 9'h000);
            if (cs_rise && st_r == ST_WDATA)
            begin
                o_prog_len <= wcnt_r;
            end
            o_persist_wr <= (sr_apply || xsr_apply) && (op_r != sesf_pkg::OP_VOL_EXT_WRITE);
            if (sr_apply || xsr_apply)
            begin
                o_persist_sr <= new_sr;
                o_persist_xsr <= xsr_apply ? rx_byte : o_persist_xsr;
            end
            o_prepare_wear <= prepare_ok && (rx_byte == sesf_pkg::OP_PREP_WEAR);
            o_prepare_supply <= prepare_ok && (rx_byte == sesf_pkg::OP_PREP_SUPPLY);
        end
    end

    assign pbuf.raddr = i_pbuf_raddr;
    assign o_pbuf_rdata = pbuf.rdata;

    sesf_pbuf u_pbuf
    (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .bus(pbuf)
    );

    // ------------------------------------------------------------
    // transmit side
    // ------------------------------------------------------------
    logic [7:0] tx_hold_r;
    logic [6:0] tx_sh_r;
    logic [18:0] ptr_r;
    logic tx_on;
    logic load_ev;
    logic [18:0] ptr_inc;
    assign tx_on = (st_r == ST_RSTREAM) || (st_r == ST_STREAM);
    // a fall before the first rise belongs to no bit
    assign load_ev = fall_ev && seen_rise_r && tx_on && (bit_cnt_r == 3'h0);
    assign ptr_inc = wrap_full_r ? (ptr_r + 19'h0_0001)
        : {ptr_r[18:16], ptr_r[15:0] + 16'h0001};

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ptr_r <= 19'h0_0000;
            o_arr_addr <= 19'h0_0000;
            o_arr_rd_en <= 1'b0;
            tx_hold_r <= 8'h00;
        end
        else
        begin
            o_arr_rd_en <= 1'b0;
            if (start_read)
            begin
                ptr_r <= addr_full[18:0];
                o_arr_addr <= addr_full[18:0];
                o_arr_rd_en <= 1'b1;
            end
            else if (load_ev && st_r == ST_RSTREAM)
            begin
                ptr_r <= ptr_inc;
                o_arr_addr <= ptr_inc;
                o_arr_rd_en <= 1'b1;
            end
            if (st_r == ST_STREAM)
            begin
                tx_hold_r <= stream_prep_r ? i_prepared_data : o_status;
            end
            else if (i_arr_rd_valid)
            begin
                tx_hold_r <= i_arr_rd_data;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_so <= 1'b0;
            o_so_oe <= 1'b0;
            tx_sh_r <= 7'h00;
        end
        else
        begin
            // floating during pause, unknown commands and outside frames
            o_so_oe <= live && tx_on && seen_rise_r;
            if (load_ev)
            begin
                o_so <= tx_hold_r[7];
                tx_sh_r <= tx_hold_r[6:0];
            end
            else if (fall_ev && seen_rise_r && tx_on)
            begin
                o_so <= tx_sh_r[6];
                tx_sh_r <= {tx_sh_r[5:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_status <= 8'h00;
        end
        else
        begin
            o_status <= {lock_en_r, 3'h0, lock_field_r, wen_r, busy};
        end
    end

endmodule // sesf_front

/* dv/sesf_front_asserts.sv */
// Purpose: pin checks for the serial front end
// Assumes: serial clock slower than eight system clocks
// Notes: attached by the bind after the module
`timescale 1ns/1ps
module sesf_front_asserts
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_hold_n,
    input wire logic [7:0] i_sector_awake,
    input wire logic o_so,
    input wire logic o_so_oe,
    input wire logic o_arr_rd_en,
    input wire logic [18:0] o_arr_addr,
    input wire logic o_prog_start,
    input wire logic [8:0] o_prog_len,
    input wire logic o_prepare_wear,
    input wire logic o_prepare_supply,
    input wire logic [7:0] o_status
);
    // ----
    // pin relations
    // ----
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // four clocks cover both sync flops and the output register
    sequence gone_s; i_cs_n [*4]; endsequence
    sequence held_s; !i_hold_n [*4]; endsequence
    cs_float_a: assert property (gone_s |-> !o_so_oe)
        else $error("so driven unselected");
    hold_float_a: assert property (held_s |-> !o_so_oe)
        else $error("so driven in pause");
    so_fall_a: assert property (o_so_oe && $past(o_so_oe) && $changed(o_so) |-> !$past(i_sck, 2))
        else $error("so moved with sck high");
    prog_len_a: assert property (o_prog_start |-> o_prog_len inside {[9'h001:9'h100]})
        else $error("bad page length");
    wen_drop_a: assert property (o_prog_start |-> ##[0:1] !o_status[sesf_pkg::SR_WEN_BIT])
        else $error("latch kept after write");
    awake_rd_a: assert property (o_arr_rd_en |-> i_sector_awake[o_arr_addr[18:16]])
        else $error("fetch from sleeping sector");
    prep_one_a: assert property (o_prepare_wear || o_prepare_supply |=> !(o_prepare_wear || o_prepare_supply))
        else $error("prepare pulse too long");
    rd_frame_a: assert property (o_arr_rd_en |-> !$past(i_cs_n, 3))
        else $error("fetch outside frame");
endmodule // sesf_front_asserts
bind sesf_front sesf_front_asserts u_chk (.i_sys_clk, .i_rst_n, .i_cs_n, .i_sck, .i_hold_n,
    .i_sector_awake, .o_so, .o_so_oe, .o_arr_rd_en, .o_arr_addr, .o_prog_start, .o_prog_len,
    .o_prepare_wear, .o_prepare_supply, .o_status);

/* dv/sesf_master.sv */
// Purpose: serial master model for the front end
// Assumes: 400 ns serial clock, floating so reads as pull-up
// Notes: the test calls its tasks
`timescale 1ns/1ps
module sesf_master
(
    input wire logic i_so_wire,
    output logic o_cs_n = 1'b1,
    output logic o_sck = 1'b0,
    output logic o_si = 1'b0,
    output logic o_hold_n = 1'b1
);
    // ----
    // frame tasks
    // ----
    logic mode3 = 1'b0;
    task automatic open_f(input logic m);
        mode3 = m;
        o_sck = m;
        #100 o_cs_n = 1'b0;
        #200;
    endtask
    // a short count leaves a partial byte
    task automatic xn(input logic [7:0] t, input int n, output logic [7:0] r);
        r = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            o_sck = 1'b0;
            o_si = t[i];
            #200 r[i] = i_so_wire;
            o_sck = 1'b1;
            #200;
        end
    endtask
    task automatic close_f();
        if (!mode3)
            o_sck = 1'b0;
        #200 o_cs_n = 1'b1;
        o_si = ~o_si;
        #400;
    endtask
    // only after a whole byte, sck high; the toggles inside must be ignored
    task automatic pause();
        #100 o_hold_n = 1'b0;
        o_si = ~o_si;
        #100 o_sck = 1'b0;
        #200 o_sck = 1'b1;
        #200 o_hold_n = 1'b1;
        #200;
    endtask
endmodule // sesf_master

/* dv/sesf_front_test.sv */
// Purpose: self-checking run of the serial front end
// Assumes: 20 MHz clock, 400 ns serial clock
// Notes: array byte is a fixed function of its address
`timescale 1ns/1ps
module sesf_front_test;
    logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_wp_n = 1'b1, i_busy = 1'b0, i_nv_load = 1'b0;
    logic i_arr_rd_valid = 1'b0, i_cs_n, i_sck, i_si, i_hold_n;
    logic [7:0] i_sector_awake = 8'hFF, i_arr_rd_data = 8'h00, i_prepared_data = 8'h5A;
    logic [7:0] i_pbuf_raddr = 8'h00, i_nv_sr = 8'h00, i_nv_xsr = 8'h00, r;
    logic o_so, o_so_oe, o_arr_rd_en, o_prog_start, o_persist_wr, o_prepare_wear;
    logic o_prepare_supply;
    logic [18:0] o_arr_addr, o_prog_addr;
    logic [8:0] o_prog_len;
    logic [7:0] o_pbuf_rdata, o_persist_sr, o_persist_xsr, o_status;
    int n_fail = 0, cmp_count = 0, n_prog = 0, n_prep = 0, n_pw = 0;
    wire so_wire = o_so_oe ? o_so : 1'b1;
    sesf_front u_dut (.*);
    sesf_master u_m (.i_so_wire(so_wire), .o_cs_n(i_cs_n), .o_sck(i_sck), .o_si(i_si),
        .o_hold_n(i_hold_n));
    always #25 i_sys_clk = ~i_sys_clk;
    // ----
    // array model and tasks
    // ----
    function automatic logic [7:0] af(input logic [18:0] a);
        return a[7:0] ^ {a[18:16], 5'h00};
    endfunction
    // data moves every clock so only the valid cycle counts
    always @(posedge i_sys_clk)
    begin
        i_arr_rd_valid <= #5 o_arr_rd_en;
        i_arr_rd_data <= #5 af(o_arr_addr);
        n_prog <= n_prog + int'(o_prog_start);
        n_prep <= n_prep + int'(o_prepare_wear) + int'(o_prepare_supply);
        n_pw <= n_pw + int'(o_persist_wr);
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            n_fail++;
            $display("[FAIL] %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic frm(input logic [63:0] b, input int nb, input logic m);
        u_m.open_f(m);
        for (int k = nb - 1; k >= 0; k--)
            u_m.xn(b[8 * k +: 8], 8, r);
    endtask
    task automatic cmd(input logic [63:0] b, input int nb);
        frm(b, nb, 1'b1);
        u_m.close_f();
    endtask
    task automatic wcmd(input logic [63:0] b, input int nb);
        cmd(64'(sesf_pkg::OP_SET_LATCH), 1);
        cmd(b, nb);
    endtask
    task automatic sr(input logic [7:0] e);
        cmd({48'h0, sesf_pkg::OP_READ_STATE, 8'h00}, 2);
        chk("status", r, e);
    endtask
    task automatic rd(input logic [18:0] a, input logic ok, input logic w);
        frm({32'h0, sesf_pkg::OP_ARRAY_READ, 5'h00, a}, 4, 1'b0);
        for (int k = 0; k < 3; k++)
        begin
            u_m.xn(8'h00, 8, r);
            chk("rdata", r, ok ? af(a) : 8'hFF);
            u_m.pause();
            a = w ? a + 19'h0_0001 : {a[18:16], a[15:0] + 16'h0001};
        end
        u_m.close_f();
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge i_sys_clk);
        #5 i_rst_n = 1'b1;
        repeat (4) @(posedge i_sys_clk);
        #5 sr(8'h00);
        cmd(64'(sesf_pkg::OP_SET_LATCH), 1);
        sr(8'h02);
        u_m.open_f(1'b0);
        u_m.xn(sesf_pkg::OP_CLEAR_LATCH, 7, r);
        u_m.close_f();
        sr(8'h02);
        cmd(64'(sesf_pkg::OP_CLEAR_LATCH), 1);
        sr(8'h00);
        wcmd({sesf_pkg::OP_WRITE_STATE, 8'h84}, 2);
        sr(8'h84);
        chk("psr", o_persist_sr, 8'h84);
        @(posedge i_sys_clk) #5 i_wp_n = 1'b0;
        wcmd({sesf_pkg::OP_WRITE_STATE, 8'h04}, 2);
        sr(8'h86);
        @(posedge i_sys_clk) #5 i_wp_n = 1'b1;
        cmd({sesf_pkg::OP_WRITE_STATE, 8'h04}, 2);
        sr(8'h04);
        wcmd({sesf_pkg::OP_ARRAY_WRITE, 32'h0600_1011}, 5);
        sr(8'h06);
        cmd({sesf_pkg::OP_ARRAY_WRITE, 48'h0500_FEA1_B2C3}, 7);
        chk("nprog", n_prog, 1);
        chk("paddr", o_prog_addr, 19'h5_00FE);
        chk("plen", o_prog_len, 9'h003);
        @(posedge i_sys_clk) #5 i_pbuf_raddr = 8'h00;
        #100;
        chk("pbuf", o_pbuf_rdata, 8'hC3);
        cmd({sesf_pkg::OP_ARRAY_WRITE, 32'h0500_1011}, 5);
        chk("nprog", n_prog, 1);
        @(posedge i_sys_clk) #5 i_busy = 1'b1;
        cmd(64'(sesf_pkg::OP_SET_LATCH), 1);
        sr(8'h05);
        rd(19'h1_0000, 1'b0, 1'b0);
        @(posedge i_sys_clk) #5 i_busy = 1'b0;
        sr(8'h04);
        cmd({8'h83, 8'h00}, 2);
        chk("inval", r, 8'hFF);
        rd(19'h7_FFFE, 1'b1, 1'b0);
        wcmd({sesf_pkg::OP_VOL_EXT_WRITE, 16'h0401}, 3);
        rd(19'h7_FFFE, 1'b1, 1'b1);
        wcmd({sesf_pkg::OP_PER_EXT_WRITE, 16'h0401}, 3);
        chk("pxsr", o_persist_xsr, 8'h01);
        chk("npw", n_pw, 3);
        @(posedge i_sys_clk) #5 i_sector_awake = 8'hDF;
        rd(19'h5_0000, 1'b0, 1'b1);
        cmd(64'(sesf_pkg::OP_PREP_WEAR), 1);
        cmd(64'(sesf_pkg::OP_PREP_SUPPLY), 1);
        chk("nprep", n_prep, 2);
        cmd({sesf_pkg::OP_FETCH_PREP, 8'h00}, 2);
        chk("fetch", r, 8'h5A);
        @(posedge i_sys_clk) #5 i_nv_load = 1'b1;
        @(posedge i_sys_clk) #5 i_nv_load = 1'b0;
        sr(8'h00);
        print_verdict();
    end
    initial
    begin
        #2_000_000;
        n_fail++;
        print_verdict();
    end
endmodule // sesf_front_test
